// *** vmlc_pkg.sv ***
package vmlc_pkg;

	// Command codes seen on the management bus
	localparam logic [7:0] VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE = 8'h21;
	localparam logic [7:0] VMLC_CMD_MARGIN_HIGH = 8'h25;
	localparam logic [7:0] VMLC_CMD_MARGIN_LOW = 8'h26;
	localparam logic [7:0] VMLC_CMD_LOOP_COMP = 8'hD7;

	// Page selector values
	localparam logic [7:0] VMLC_PAGE_A = 8'h00;
	localparam logic [7:0] VMLC_PAGE_B = 8'h01;
	localparam logic [7:0] VMLC_PAGE_ALL = 8'hFF;

	// Field layout
	localparam int VMLC_VID_W = 8;
	localparam int VMLC_COMP_W = 14;
	localparam int VMLC_INT_GAIN_LSB = 12;
	localparam int VMLC_INT_TIME_LSB = 8;
	localparam int VMLC_AC_PATH_GAIN_SEL_LSB = 6;
	localparam int VMLC_LOAD_LINE_LSB = 0;

	// Reset values, before the NVM image arrives
	localparam logic [7:0] VMLC_CMD_RESET = 8'h00;
	localparam logic [7:0] VMLC_LOW_RESET = 8'h00;
	localparam logic [7:0] VMLC_HIGH_RESET = 8'h00;
	localparam logic [13:0] VMLC_COMP_RESET = 14'h0000;

	// Margin field codes of the operation register
	localparam logic [3:0] VMLC_MARGIN_OFF = 4'h0;
	localparam logic [3:0] VMLC_MARGIN_LOW_IGN = 4'h5;
	localparam logic [3:0] VMLC_MARGIN_LOW_ACT = 4'h6;
	localparam logic [3:0] VMLC_MARGIN_HIGH_IGN = 4'h9;
	localparam logic [3:0] VMLC_MARGIN_HIGH_ACT = 4'hA;

	// Integrator time constant steps, microseconds
	localparam logic [5:0] VMLC_TC_SLOW_STEP_US = 6'h05;
	localparam logic [5:0] VMLC_TC_FAST_STEP_US = 6'h01;

	// AC path gain in quarter units: 1, 1.5, 2, 0.5
	localparam logic [3:0] VMLC_ACG_Q4_00 = 4'h4;
	localparam logic [3:0] VMLC_ACG_Q4_01 = 4'h6;
	localparam logic [3:0] VMLC_ACG_Q4_10 = 4'h8;
	localparam logic [3:0] VMLC_ACG_Q4_11 = 4'h2;

	// Integrator gain relative to Ac_path_gain_sel, percent: 200, 100, 66, 50
	localparam logic [7:0] VMLC_ING_PCT_00 = 8'hC8;
	localparam logic [7:0] VMLC_ING_PCT_01 = 8'h64;
	localparam logic [7:0] VMLC_ING_PCT_10 = 8'h42;
	localparam logic [7:0] VMLC_ING_PCT_11 = 8'h32;

	typedef enum logic [1:0] {VMLC_TSEL_CMD, VMLC_TSEL_LOW, VMLC_TSEL_HIGH} vmlc_tsel_t;
	typedef enum logic {VMLC_ST_WAIT_NVM, VMLC_ST_RUN} vmlc_state_t;

	function automatic logic [7:0] vmlc_clamp(input logic [7:0] code, input logic [7:0] max);
		vmlc_clamp = (code > max) ? max : code;
	endfunction

	function automatic vmlc_tsel_t vmlc_margin_sel(input logic [3:0] margin);
		case (margin)
			VMLC_MARGIN_LOW_IGN, VMLC_MARGIN_LOW_ACT: vmlc_margin_sel = VMLC_TSEL_LOW;
			VMLC_MARGIN_HIGH_IGN, VMLC_MARGIN_HIGH_ACT: vmlc_margin_sel = VMLC_TSEL_HIGH;
			default: vmlc_margin_sel = VMLC_TSEL_CMD;
		endcase
	endfunction

endpackage

// *** vmlc_chan_regs.sv ***
`timescale 1ns/1ps
module vmlc_chan_regs import vmlc_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// NVM image
	input wire logic nvm_load_in,
	input wire logic [7:0] nvm_cmd_in,
	input wire logic [7:0] nvm_low_in,
	input wire logic [7:0] nvm_high_in,
	input wire logic [13:0] nvm_comp_in,
	// Accepted word writes
	input wire logic wr_cmd_in,
	input wire logic wr_low_in,
	input wire logic wr_high_in,
	input wire logic wr_comp_in,
	input wire logic [15:0] wr_data_in,
	// Limit and mode
	input wire logic [7:0] vout_max_in,
	input wire logic [3:0] margin_in,
	// Stored values
	output logic [7:0] cmd_out,
	output logic [7:0] low_out,
	output logic [7:0] high_out,
	output logic [13:0] comp_out,
	output logic [7:0] target_out
);
	logic [7:0] cmd_reg, low_reg, high_reg, target_reg;
	logic [13:0] comp_reg;
	logic [7:0] target_next;
	vmlc_tsel_t tsel;

	assign tsel = vmlc_margin_sel(margin_in);
	assign target_next = (tsel == VMLC_TSEL_LOW) ? low_reg :
		(tsel == VMLC_TSEL_HIGH) ? high_reg :
		vmlc_clamp(cmd_reg, vout_max_in);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_reg <= VMLC_CMD_RESET;
			low_reg <= VMLC_LOW_RESET;
			high_reg <= VMLC_HIGH_RESET;
			comp_reg <= VMLC_COMP_RESET;
			target_reg <= VMLC_CMD_RESET;
		end else begin
			target_reg <= target_next;
			// Host write of the same cycle wins over an NVM reload
			if (wr_cmd_in) cmd_reg <= vmlc_clamp(wr_data_in[7:0], vout_max_in);
			else if (nvm_load_in) cmd_reg <= vmlc_clamp(nvm_cmd_in, vout_max_in);
			if (wr_low_in) low_reg <= wr_data_in[7:0];
			else if (nvm_load_in) low_reg <= nvm_low_in;
			if (wr_high_in) high_reg <= wr_data_in[7:0];
			else if (nvm_load_in) high_reg <= nvm_high_in;
			if (wr_comp_in) comp_reg <= wr_data_in[13:0];
			else if (nvm_load_in) comp_reg <= nvm_comp_in;
		end
	end

	assign cmd_out = cmd_reg;
	assign low_out = low_reg;
	assign high_out = high_reg;
	assign comp_out = comp_reg;
	assign target_out = target_reg;
endmodule // vmlc_chan_regs

// *** vmlc_loop_decode.sv ***
`timescale 1ns/1ps
module vmlc_loop_decode import vmlc_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Stored compensation word
	input wire logic [13:0] comp_in,
	// Decoded settings
	output logic [5:0] tc_us_out,
	output logic [3:0] ac_path_gain_sel_q4_out,
	output logic [7:0] int_gain_pct_out,
	output logic [5:0] ac_load_line_sel_out
);
	logic [1:0] int_gain_sel, ac_path_gain_sel;
	logic [3:0] integrator_time_sel;
	logic [5:0] tc_next;
	logic [3:0] acg_next;
	logic [7:0] ing_next;

	assign int_gain_sel = comp_in[VMLC_INT_GAIN_LSB +: 2];
	assign integrator_time_sel = comp_in[VMLC_INT_TIME_LSB +: 4];
	assign ac_path_gain_sel = comp_in[VMLC_AC_PATH_GAIN_SEL_LSB +: 2];

	// Upper half of the code space is the fine 1 us range
	assign tc_next = integrator_time_sel[3] ?
		6'({3'h0, integrator_time_sel[2:0]} + 6'h01) * VMLC_TC_FAST_STEP_US :
		6'({3'h0, integrator_time_sel[2:0]} + 6'h01) * VMLC_TC_SLOW_STEP_US;
	assign acg_next = (ac_path_gain_sel == 2'h0) ? VMLC_ACG_Q4_00 :
		(ac_path_gain_sel == 2'h1) ? VMLC_ACG_Q4_01 :
		(ac_path_gain_sel == 2'h2) ? VMLC_ACG_Q4_10 : VMLC_ACG_Q4_11;
	assign ing_next = (int_gain_sel == 2'h0) ? VMLC_ING_PCT_00 :
		(int_gain_sel == 2'h1) ? VMLC_ING_PCT_01 :
		(int_gain_sel == 2'h2) ? VMLC_ING_PCT_10 : VMLC_ING_PCT_11;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tc_us_out <= 6'h00;
			ac_path_gain_sel_q4_out <= 4'h0;
			int_gain_pct_out <= 8'h00;
			ac_load_line_sel_out <= 6'h00;
		end else begin
			tc_us_out <= tc_next;
			ac_path_gain_sel_q4_out <= acg_next;
			int_gain_pct_out <= ing_next;
			ac_load_line_sel_out <= comp_in[VMLC_LOAD_LINE_LSB +: 6];
		end
	end
endmodule // vmlc_loop_decode

// *** vmlc_regs.sv ***
// Notes on behaviour
// - Each channel keeps an 8-bit commanded voltage code, written through the page.
// - Page 00h hits channel A, 01h channel B, FFh both channels at once for voltage writes; FFh reads return channel A.
// - Commanded code is clamped to the channel's maximum voltage code when written or loaded; the commanded target re-clamps to the current maximum.
// - Commanded code is loaded from the NVM image at power-up.
// - Margin-low code per channel, reset 00h, is the target in margin low.
// - Margin-high code per channel is the target in margin high.
// - Compensation word is per channel, reached by page 00h or 01h, word only.
// - Compensation bits 15:14 are read-only and read as zero.
// - Fields: integrator gain 13:12, time 11:8, Ac_path_gain_sel 7:6, load line 5:0.
// - Integrator gain code scales Ac_path_gain_sel by 2, 1, 0.66 or 0.5.
// - Time code 0-7 gives 5-40 us by 5; 8-15 gives 1-8 us by 1.
// - Ramp amplitude comes from its own command, not the compensation word.
// - Ac_path_gain_sel code decodes to 1, 1.5, 2 or 0.5.
// - Margin field picks commanded, margin-low (0101b/0110b) or margin-high (1001b/1010b).
`timescale 1ns/1ps
module vmlc_regs import vmlc_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Page selector and operation margin fields
	input wire logic [7:0] page_in,
	input wire logic [3:0] margin_a_in,
	input wire logic [3:0] margin_b_in,
	// Maximum output voltage codes
	input wire logic [7:0] vout_max_a_in,
	input wire logic [7:0] vout_max_b_in,
	// NVM image
	input wire logic nvm_load_in,
	input wire logic [7:0] nvm_cmd_a_in,
	input wire logic [7:0] nvm_low_a_in,
	input wire logic [7:0] nvm_high_a_in,
	input wire logic [13:0] nvm_comp_a_in,
	input wire logic [7:0] nvm_cmd_b_in,
	input wire logic [7:0] nvm_low_b_in,
	input wire logic [7:0] nvm_high_b_in,
	input wire logic [13:0] nvm_comp_b_in,
	// Write transaction
	input wire logic wr_req_in,
	input wire logic wr_word_in,
	input wire logic [7:0] wr_cmd_in,
	input wire logic [15:0] wr_data_in,
	output logic wr_ack_out,
	output logic wr_nack_out,
	// Read transaction
	input wire logic rd_req_in,
	input wire logic rd_word_in,
	input wire logic [7:0] rd_cmd_in,
	output logic rd_valid_out,
	output logic rd_nack_out,
	output logic [15:0] rd_data_out,
	// Status
	output logic nvm_loaded_out,
	// Channel A targets and loop settings
	output logic [7:0] target_code_a_out,
	output logic [5:0] int_time_us_a_out,
	output logic [3:0] ac_path_gain_sel_q4_a_out,
	output logic [7:0] int_gain_pct_a_out,
	output logic [5:0] ac_load_line_sel_a_out,
	// Channel B targets and loop settings
	output logic [7:0] target_code_b_out,
	output logic [5:0] int_time_us_b_out,
	output logic [3:0] ac_path_gain_sel_q4_b_out,
	output logic [7:0] int_gain_pct_b_out,
	output logic [5:0] ac_load_line_sel_b_out
);
	logic rst_sync1_reg, rst_sync2_reg;
	logic rst_n;
	vmlc_state_t state_reg, state_next;

	// Reset release through two flops
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// Host access waits for the NVM image so no one reads stale reset codes
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			VMLC_ST_WAIT_NVM: begin
				if (nvm_load_in) state_next = VMLC_ST_RUN;
			end
			VMLC_ST_RUN: state_next = VMLC_ST_RUN;
			default: state_next = VMLC_ST_WAIT_NVM;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= VMLC_ST_WAIT_NVM;
		end else begin
			state_reg <= state_next;
		end
	end

	wire running = (state_reg == VMLC_ST_RUN);

	// Page decode shared by reads and writes
	wire page_a = (page_in == VMLC_PAGE_A);
	wire page_b = (page_in == VMLC_PAGE_B);
	wire page_all = (page_in == VMLC_PAGE_ALL);
	wire hit_a = page_a | page_all;
	wire hit_b = page_b | page_all;

	// Write command decode
	wire wr_is_cmd = (wr_cmd_in == VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE);
	wire wr_is_low = (wr_cmd_in == VMLC_CMD_MARGIN_LOW);
	wire wr_is_high = (wr_cmd_in == VMLC_CMD_MARGIN_HIGH);
	wire wr_is_comp = (wr_cmd_in == VMLC_CMD_LOOP_COMP);
	wire wr_is_vout = wr_is_cmd | wr_is_low | wr_is_high;

	// Compensation has no broadcast page; FFh is refused for it
	wire wr_page_ok = wr_is_vout ? (hit_a | hit_b) : (page_a | page_b);
	// Byte writes are refused outright; a half-written word never lands
	wire wr_accept = wr_req_in & wr_word_in & running & (wr_is_vout | wr_is_comp) &
		wr_page_ok;
	wire wr_refuse = wr_req_in & ~wr_accept;

	wire wr_a = wr_accept & (wr_is_vout ? hit_a : page_a);
	wire wr_b = wr_accept & (wr_is_vout ? hit_b : page_b);

	// Read command decode
	wire rd_is_cmd = (rd_cmd_in == VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE);
	wire rd_is_low = (rd_cmd_in == VMLC_CMD_MARGIN_LOW);
	wire rd_is_high = (rd_cmd_in == VMLC_CMD_MARGIN_HIGH);
	wire rd_is_comp = (rd_cmd_in == VMLC_CMD_LOOP_COMP);
	wire rd_is_vout = rd_is_cmd | rd_is_low | rd_is_high;
	wire rd_page_ok = rd_is_vout ? (hit_a | hit_b) : (page_a | page_b);
	wire rd_accept = rd_req_in & rd_word_in & running & (rd_is_vout | rd_is_comp) &
		rd_page_ok;
	// Broadcast page reads return channel A
	wire rd_sel_b = page_b;

	// Per-channel storage
	logic [7:0] cmd_a, low_a, high_a, cmd_b, low_b, high_b;
	logic [13:0] comp_a, comp_b;

	vmlc_chan_regs u_chan_a (
		.clk_in(mclk_in),
		.rst_n_in(rst_n),
		.nvm_load_in(nvm_load_in),
		.nvm_cmd_in(nvm_cmd_a_in),
		.nvm_low_in(nvm_low_a_in),
		.nvm_high_in(nvm_high_a_in),
		.nvm_comp_in(nvm_comp_a_in),
		.wr_cmd_in(wr_a & wr_is_cmd),
		.wr_low_in(wr_a & wr_is_low),
		.wr_high_in(wr_a & wr_is_high),
		.wr_comp_in(wr_a & wr_is_comp),
		.wr_data_in(wr_data_in),
		.vout_max_in(vout_max_a_in),
		.margin_in(margin_a_in),
		.cmd_out(cmd_a),
		.low_out(low_a),
		.high_out(high_a),
		.comp_out(comp_a),
		.target_out(target_code_a_out)
	);

	vmlc_chan_regs u_chan_b (
		.clk_in(mclk_in),
		.rst_n_in(rst_n),
		.nvm_load_in(nvm_load_in),
		.nvm_cmd_in(nvm_cmd_b_in),
		.nvm_low_in(nvm_low_b_in),
		.nvm_high_in(nvm_high_b_in),
		.nvm_comp_in(nvm_comp_b_in),
		.wr_cmd_in(wr_b & wr_is_cmd),
		.wr_low_in(wr_b & wr_is_low),
		.wr_high_in(wr_b & wr_is_high),
		.wr_comp_in(wr_b & wr_is_comp),
		.wr_data_in(wr_data_in),
		.vout_max_in(vout_max_b_in),
		.margin_in(margin_b_in),
		.cmd_out(cmd_b),
		.low_out(low_b),
		.high_out(high_b),
		.comp_out(comp_b),
		.target_out(target_code_b_out)
	);

	// Ramp height is configured elsewhere and never enters this decode
	vmlc_loop_decode u_dec_a (
		.clk_in(mclk_in),
		.rst_n_in(rst_n),
		.comp_in(comp_a),
		.tc_us_out(int_time_us_a_out),
		.ac_path_gain_sel_q4_out(ac_path_gain_sel_q4_a_out),
		.int_gain_pct_out(int_gain_pct_a_out),
		.ac_load_line_sel_out(ac_load_line_sel_a_out)
	);

	vmlc_loop_decode u_dec_b (
		.clk_in(mclk_in),
		.rst_n_in(rst_n),
		.comp_in(comp_b),
		.tc_us_out(int_time_us_b_out),
		.ac_path_gain_sel_q4_out(ac_path_gain_sel_q4_b_out),
		.int_gain_pct_out(int_gain_pct_b_out),
		.ac_load_line_sel_out(ac_load_line_sel_b_out)
	);

	// Read data selection; upper bits are read-only zero
	wire [7:0] rd_cmd_sel = rd_sel_b ? cmd_b : cmd_a;
	wire [7:0] rd_low_sel = rd_sel_b ? low_b : low_a;
	wire [7:0] rd_high_sel = rd_sel_b ? high_b : high_a;
	wire [13:0] rd_comp_sel = rd_sel_b ? comp_b : comp_a;
	wire [15:0] rd_word = rd_is_cmd ? {8'h00, rd_cmd_sel} :
		rd_is_low ? {8'h00, rd_low_sel} :
		rd_is_high ? {8'h00, rd_high_sel} :
		rd_is_comp ? {2'b00, rd_comp_sel} : 16'h0000;

	logic wr_ack_reg, wr_nack_reg, rd_valid_reg, rd_nack_reg, loaded_reg;
	logic [15:0] rd_data_reg;

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			wr_ack_reg <= 1'b0;
			wr_nack_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_nack_reg <= 1'b0;
			rd_data_reg <= 16'h0000;
			loaded_reg <= 1'b0;
		end else begin
			wr_ack_reg <= wr_accept;
			wr_nack_reg <= wr_refuse;
			rd_valid_reg <= rd_accept;
			rd_nack_reg <= rd_req_in & ~rd_accept;
			if (rd_accept) rd_data_reg <= rd_word;
			if (nvm_load_in) loaded_reg <= 1'b1;
		end
	end

	assign wr_ack_out = wr_ack_reg;
	assign wr_nack_out = wr_nack_reg;
	assign rd_valid_out = rd_valid_reg;
	assign rd_nack_out = rd_nack_reg;
	assign rd_data_out = rd_data_reg;
	assign nvm_loaded_out = loaded_reg;
endmodule // vmlc_regs

// *** vmlc_regs_checker.sv ***
`timescale 1ns/1ps
module vmlc_regs_checker import vmlc_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Host side
	input wire logic [7:0] page_in,
	input wire logic [3:0] margin_a_in,
	input wire logic [7:0] vout_max_a_in,
	input wire logic nvm_load_in,
	input wire logic wr_req_in,
	input wire logic wr_word_in,
	input wire logic [7:0] wr_cmd_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_ack_out,
	input wire logic wr_nack_out,
	input wire logic rd_req_in,
	input wire logic rd_word_in,
	input wire logic [7:0] rd_cmd_in,
	input wire logic rd_valid_out,
	input wire logic rd_nack_out,
	input wire logic [15:0] rd_data_out,
	// Load flag and channel A results
	input wire logic nvm_loaded_out,
	input wire logic [7:0] target_code_a_out,
	input wire logic [5:0] int_time_us_a_out,
	input wire logic [3:0] ac_path_gain_sel_q4_a_out,
	input wire logic [7:0] int_gain_pct_a_out
);
	localparam logic [3:0] ACG_Q4 [4] = '{4'h4, 4'h6, 4'h8, 4'h2};
	localparam logic [7:0] ING_PCT [4] = '{8'hC8, 8'h64, 8'h42, 8'h32};
	logic [15:0] data_d1_reg;
	logic [15:0] data_d2_reg;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);

	// Write data two edges back, lined up with the decode latency
	always_ff @(posedge mclk_in) begin
		data_d1_reg <= wr_data_in;
		data_d2_reg <= data_d1_reg;
	end

	function automatic logic [5:0] tc_us(input logic [2:0] c, input logic fast);
		tc_us = fast ? 6'(c) + 6'h01 : (6'(c) + 6'h01) * 6'h05;
	endfunction

	sequence s_comp_a;
		wr_req_in && wr_word_in && wr_cmd_in == VMLC_CMD_LOOP_COMP && page_in == VMLC_PAGE_A
			##1 wr_ack_out;
	endsequence

	a_wr_one_answer: assert property (wr_req_in |=> wr_ack_out != wr_nack_out)
		else $error("write not answered by exactly one of ack and nack");
	a_byte_wr_refused: assert property (wr_req_in && !wr_word_in |=> wr_nack_out)
		else $error("byte write not refused");
	a_byte_rd_refused: assert property (rd_req_in && !rd_word_in |=>
		rd_nack_out && $stable(rd_data_out))
		else $error("byte read not refused or read data moved");
	a_loop_all_refused: assert property (wr_req_in && wr_cmd_in == VMLC_CMD_LOOP_COMP &&
		page_in == VMLC_PAGE_ALL |=> wr_nack_out)
		else $error("compensation write to both channels not refused");
	a_loop_top_zero: assert property (rd_req_in && rd_cmd_in == VMLC_CMD_LOOP_COMP ##1
		rd_valid_out |-> rd_data_out[15:14] == 2'b00)
		else $error("compensation read top bits not zero");
	a_vid_top_zero: assert property (rd_req_in && rd_cmd_in != VMLC_CMD_LOOP_COMP ##1
		rd_valid_out |-> rd_data_out[15:8] == 8'h00)
		else $error("voltage read upper byte not zero");
	a_cmd_clamped: assert property ($past(margin_a_in) == VMLC_MARGIN_OFF &&
		$stable(vout_max_a_in) |-> target_code_a_out <= vout_max_a_in)
		else $error("commanded target above maximum");
	a_tc_decode: assert property (s_comp_a |=>
		int_time_us_a_out == tc_us(data_d2_reg[10:8], data_d2_reg[11]))
		else $error("time constant decode wrong");
	a_acg_decode: assert property (s_comp_a |=>
		ac_path_gain_sel_q4_a_out == ACG_Q4[data_d2_reg[7:6]])
		else $error("ac_path_gain_sel decode wrong");
	a_ing_decode: assert property (s_comp_a |=>
		int_gain_pct_a_out == ING_PCT[data_d2_reg[13:12]])
		else $error("integrator gain decode wrong");
	a_nvm_flag: assert property (nvm_load_in |=> nvm_loaded_out [*3])
		else $error("load flag not raised and held");

	c_write_ok: cover property (wr_ack_out);
	c_margin_low: cover property (margin_a_in == VMLC_MARGIN_LOW_ACT);
	c_comp_write: cover property (s_comp_a);
endmodule // vmlc_regs_checker

bind vmlc_regs vmlc_regs_checker i_checker (.*);

// *** vmlc_host.sv ***
`timescale 1ns/1ps
module vmlc_host (
	// Clock
	input wire logic clk_in,
	// Write side
	output logic wr_req_out,
	output logic wr_word_out,
	output logic [7:0] wr_cmd_out,
	output logic [15:0] wr_data_out,
	input wire logic wr_ack_in,
	input wire logic wr_nack_in,
	// Read side
	output logic rd_req_out,
	output logic rd_word_out,
	output logic [7:0] rd_cmd_out,
	input wire logic rd_valid_in,
	input wire logic rd_nack_in,
	input wire logic [15:0] rd_data_in
);
	initial begin
		wr_req_out = 1'b0;
		wr_word_out = 1'b1;
		wr_cmd_out = 8'h00;
		wr_data_out = 16'h0000;
		rd_req_out = 1'b0;
		rd_word_out = 1'b1;
		rd_cmd_out = 8'h00;
	end

	// One request per call, answer taken the cycle after; released fields show inverted data
	task automatic wr(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [1:0] ans);
		@(posedge clk_in);
		#1;
		wr_req_out = 1'b1;
		wr_word_out = w;
		wr_cmd_out = c;
		wr_data_out = d;
		@(posedge clk_in);
		#1;
		ans = {wr_ack_in, wr_nack_in};
		wr_req_out = 1'b0;
		wr_cmd_out = ~c;
		wr_data_out = ~d;
	endtask

	task automatic rd(input logic w, input logic [7:0] c, output logic [1:0] ans,
		output logic [15:0] d);
		@(posedge clk_in);
		#1;
		rd_req_out = 1'b1;
		rd_word_out = w;
		rd_cmd_out = c;
		@(posedge clk_in);
		#1;
		ans = {rd_valid_in, rd_nack_in};
		d = rd_data_in;
		rd_req_out = 1'b0;
		rd_cmd_out = ~c;
	endtask
endmodule // vmlc_host

// *** vmlc_regs_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module vmlc_regs_tb import vmlc_pkg::*;;
	logic mclk_in, reset_n_in, nvm_load_in, nvm_loaded_out;
	logic [7:0] page_in, vout_max_a_in, vout_max_b_in, wr_cmd_in, rd_cmd_in;
	logic [3:0] margin_a_in, margin_b_in, ac_path_gain_sel_q4_a_out, ac_path_gain_sel_q4_b_out;
	logic [7:0] nvm_cmd_a_in, nvm_low_a_in, nvm_high_a_in, nvm_cmd_b_in, nvm_low_b_in, nvm_high_b_in;
	logic [13:0] nvm_comp_a_in, nvm_comp_b_in;
	logic wr_req_in, wr_word_in, wr_ack_out, wr_nack_out;
	logic rd_req_in, rd_word_in, rd_valid_out, rd_nack_out;
	logic [15:0] wr_data_in, rd_data_out, rdv, d;
	logic [7:0] target_code_a_out, target_code_b_out, int_gain_pct_a_out, int_gain_pct_b_out;
	logic [5:0] int_time_us_a_out, int_time_us_b_out, ac_load_line_sel_a_out, ac_load_line_sel_b_out;
	logic [1:0] ans;
	int errors = 0;
	int samples_checked = 0;

	vmlc_regs i_dut (.*);
	vmlc_host i_host (.clk_in(mclk_in), .wr_req_out(wr_req_in), .wr_word_out(wr_word_in),
		.wr_cmd_out(wr_cmd_in), .wr_data_out(wr_data_in), .wr_ack_in(wr_ack_out),
		.wr_nack_in(wr_nack_out), .rd_req_out(rd_req_in), .rd_word_out(rd_word_in),
		.rd_cmd_out(rd_cmd_in), .rd_valid_in(rd_valid_out), .rd_nack_in(rd_nack_out),
		.rd_data_in(rd_data_out));

	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] pg, input logic [7:0] c, input logic [15:0] v,
		input logic [1:0] ex);
		page_in = pg;
		i_host.wr(1'b1, c, v, ans);
		`CHK("write answer", ex, ans);
	endtask

	task automatic rd(input logic [7:0] pg, input logic [7:0] c, input logic [15:0] ex);
		page_in = pg;
		i_host.rd(1'b1, c, ans, rdv);
		`CHK("read answer", 2'b10, ans);
		`CHK("read data", ex, rdv);
	endtask

	task automatic s_start();
		`CHK("reset target", 8'h00, target_code_a_out);
		wr(VMLC_PAGE_A, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0011, 2'b01);
		nvm_load_in = 1'b1;
		tick(1);
		nvm_load_in = 1'b0;
		tick(1);
		`CHK("loaded flag", 1'b1, nvm_loaded_out);
		rd(VMLC_PAGE_A, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0040);
		rd(VMLC_PAGE_A, VMLC_CMD_MARGIN_LOW, 16'h0020);
		rd(VMLC_PAGE_B, VMLC_CMD_LOOP_COMP, 16'h1A5C);
	endtask

	task automatic s_page();
		wr(VMLC_PAGE_ALL, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'hAB33, 2'b10);
		rd(VMLC_PAGE_B, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0033);
		wr(VMLC_PAGE_B, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0055, 2'b10);
		rd(VMLC_PAGE_A, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0033);
		wr(8'h02, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0066, 2'b01);
		i_host.wr(1'b0, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0077, ans);
		`CHK("byte write", 2'b01, ans);
		i_host.rd(1'b0, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, ans, rdv);
		`CHK("byte read", 2'b01, ans);
		rd(VMLC_PAGE_B, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0055);
		`CHK("target b", 8'h55, target_code_b_out);
	endtask

	task automatic s_clamp();
		vout_max_a_in = 8'h50;
		wr(VMLC_PAGE_A, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0077, 2'b10);
		rd(VMLC_PAGE_A, VMLC_CMD_COMMANDED_OUTPUT_VOLTAGE, 16'h0050);
		`CHK("clamped target", 8'h50, target_code_a_out);
		vout_max_a_in = 8'h30;
		tick(2);
		`CHK("lowered max", 8'h30, target_code_a_out);
	endtask

	task automatic s_margin();
		logic [3:0] mc [6] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'hA, 4'hF};
		logic [7:0] mt [6] = '{8'h30, 8'h12, 8'h12, 8'hE8, 8'hE8, 8'h30};
		wr(VMLC_PAGE_A, VMLC_CMD_MARGIN_LOW, 16'hFF12, 2'b10);
		wr(VMLC_PAGE_A, VMLC_CMD_MARGIN_HIGH, 16'h00E8, 2'b10);
		for (int i = 0; i < 6; i++) begin
			margin_a_in = mc[i];
			tick(2);
			`CHK("margin target", mt[i], target_code_a_out);
		end
		margin_a_in = 4'h0;
		margin_b_in = 4'hA;
		tick(2);
		`CHK("margin target b", 8'h61, target_code_b_out);
		margin_b_in = 4'h0;
	endtask

	task automatic s_comp();
		logic [3:0] acg [4] = '{4'h4, 4'h6, 4'h8, 4'h2};
		logic [7:0] ing [4] = '{8'hC8, 8'h64, 8'h42, 8'h32};
		for (int i = 0; i < 16; i++) begin
			d = {2'b11, 2'(i), 4'(i), 2'(i + 1), 6'(i * 3)};
			wr(VMLC_PAGE_A, VMLC_CMD_LOOP_COMP, d, 2'b10);
			tick(1);
			`CHK("time const", 6'((i < 8) ? 5 * (i + 1) : i - 7), int_time_us_a_out);
			`CHK("ac_path_gain_sel", acg[2'(i + 1)], ac_path_gain_sel_q4_a_out);
			`CHK("int gain", ing[2'(i)], int_gain_pct_a_out);
			`CHK("load line", 6'(i * 3), ac_load_line_sel_a_out);
			rd(VMLC_PAGE_A, VMLC_CMD_LOOP_COMP, {2'b00, d[13:0]});
		end
		wr(VMLC_PAGE_ALL, VMLC_CMD_LOOP_COMP, 16'h0101, 2'b01);
		rd(VMLC_PAGE_B, VMLC_CMD_LOOP_COMP, 16'h1A5C);
		`CHK("b time const", 6'h03, int_time_us_b_out);
		`CHK("b ac_path_gain_sel", VMLC_ACG_Q4_01, ac_path_gain_sel_q4_b_out);
		`CHK("b int gain", VMLC_ING_PCT_01, int_gain_pct_b_out);
		`CHK("b load line", 6'h1C, ac_load_line_sel_b_out);
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#300000;
		errors++;
		end_sim();
	end

	initial begin
		reset_n_in = 1'b0;
		nvm_load_in = 1'b0;
		page_in = 8'h00;
		{margin_a_in, margin_b_in} = 8'h00;
		{vout_max_a_in, vout_max_b_in} = 16'hF0F0;
		{nvm_cmd_a_in, nvm_low_a_in, nvm_high_a_in} = 24'h402060;
		{nvm_cmd_b_in, nvm_low_b_in, nvm_high_b_in} = 24'h412161;
		nvm_comp_a_in = 14'h2345;
		nvm_comp_b_in = 14'h1A5C;
		tick(2);
		reset_n_in = 1'b1;
		tick(3);
		s_start();
		s_page();
		s_clamp();
		s_margin();
		s_comp();
		end_sim();
	end
endmodule // vmlc_regs_tb
